/* File: logic/mch_pkg.sv */
// constants of the monitor channel handshake block: register map, field layout, frame geometry
// assumes a 32-bit APB slave and an IOM-2 terminal frame of three sub-channels
package mch_pkg;

	localparam int unsigned ADDR_W = 8;

	// register byte offsets
	localparam logic [7:0] CTRL_OFS = 8'h00;
	localparam logic [7:0] STAT_OFS = 8'h04;
	localparam logic [7:0] MASK_OFS = 8'h08;
	localparam logic [7:0] ACT_OFS  = 8'h0C;
	localparam logic [7:0] TXB_OFS  = 8'h10;
	localparam logic [7:0] RXB_OFS  = 8'h14;

	// msg_control_register fields
	localparam int unsigned CTRL_W       = 5;
	localparam int unsigned CTL_RX_ACK   = 0;
	localparam int unsigned CTL_TX_VALID = 1;
	localparam int unsigned CTL_RX_IRQEN = 2;
	localparam int unsigned CTL_TX_IRQEN = 3;
	localparam int unsigned CTL_SUBCH    = 4;
	localparam logic [4:0]  CTRL_RST     = 5'h00;

	// msg_status_register fields, also the mask layout
	localparam int unsigned STAT_W      = 4;
	localparam int unsigned ST_RECEIVED = 0;
	localparam int unsigned ST_END_RX   = 1;
	localparam int unsigned ST_ACKED    = 2;
	localparam int unsigned ST_ABORT    = 3;
	localparam logic [3:0]  STAT_RST    = 4'h0;
	localparam logic [3:0]  MASK_RST    = 4'h0;

	localparam logic [7:0]  BYTE_RST = 8'hFF;

	// frame geometry in bit times, msb first in each octet
	localparam int unsigned CNT_W     = 7;
	localparam logic [6:0]  LAST_BIT  = 7'h5F;
	localparam logic [6:0]  CH_BITS   = 7'h20;
	localparam logic [6:0]  MON_OFS   = 7'h10;
	localparam logic [6:0]  MON_LEN   = 7'h08;
	localparam logic [6:0]  MR_OFS    = 7'h1E;
	localparam logic [6:0]  MX_OFS    = 7'h1F;

	localparam int unsigned SYNC_W = 3;

endpackage

/* File: logic/mch_sync.sv */
// three-stage synchroniser for pins from outside the clock domain
// a change is passed on once the second and third stages agree
`timescale 1ns/1ps

module mch_sync #(
	parameter int unsigned W = 1
) (
	input  wire logic         clk,
	input  wire logic         rst_b,
	input  wire logic [W-1:0] pin,
	output logic      [W-1:0] level
);

	logic [W-1:0] s1_q;
	logic [W-1:0] s2_q;
	logic [W-1:0] s3_q;
	logic [W-1:0] level_q;

	genvar g;
	generate
		for (g = 0; g < W; g++) begin : g_bit
			always_ff @(posedge clk or negedge rst_b) begin
				if (!rst_b) begin
					s1_q[g]    <= 1'b1;
					s2_q[g]    <= 1'b1;
					s3_q[g]    <= 1'b1;
					level_q[g] <= 1'b1;
				end else begin
					s1_q[g] <= pin[g];
					s2_q[g] <= s1_q[g];
					s3_q[g] <= s2_q[g];
					if (s2_q[g] == s3_q[g]) begin
						level_q[g] <= s3_q[g];
					end
				end
			end
		end
	endgenerate

	assign level = level_q;

endmodule

/* File: logic/mch_top.sv */
// monitor channel handshake: APB registers, IOM-2 frame slotting, transmitter and receiver
// assumes dcl, fsc and din come from the bus unsynchronised; dout is open drain
//
// Added by the designer: the APB slave port and the register addresses.
`timescale 1ns/1ps

module mch_top (
	input  wire logic                       clk,
	input  wire logic                       rst_b,
	input  wire logic                       psel,
	input  wire logic                       penable,
	input  wire logic                       pwrite,
	input  wire logic [mch_pkg::ADDR_W-1:0] paddr,
	input  wire logic [31:0]                pwdata,
	output logic      [31:0]                prdata,
	output logic                            pready,
	output logic                            pslverr,
	output logic                            irq,
	input  wire logic                       dcl,
	input  wire logic                       fsc,
	input  wire logic                       din,
	output logic                            dout_o,
	output logic                            dout_oe_b,
	input  wire logic                       core_tx_bit,
	output logic                            core_rx_bit
);

	typedef enum logic [2:0] {
		TX_IDLE, TX_FIRST, TX_ACKED, TX_PULSE, TX_WAIT, TX_CLOSE
	} mch_tx_state_t;

	typedef enum logic [1:0] {
		RX_OFF, RX_ACK, RX_HOLD, RX_PULSE
	} mch_rx_state_t;

	function automatic logic reg_hit(input logic [7:0] a, input logic [7:0] ofs);
		reg_hit = (a == ofs);
	endfunction

	// true while cnt lies in [ch*32+ofs, ch*32+ofs+len)
	function automatic logic in_field(input logic [6:0] cnt, input logic ch,
		input logic [6:0] ofs, input logic [6:0] len);
		logic [6:0] base;
		base = (ch ? mch_pkg::CH_BITS : 7'h00) + ofs;
		in_field = (cnt >= base) && (cnt < base + len);
	endfunction

	////////////////////////////////////////////////////////////////////////////////

	logic [2:0]                  pins_s;
	logic                        dcl_s;
	logic                        fsc_s;
	logic                        din_s;
	logic                        dcl_q;
	logic                        fsc_q;
	logic [mch_pkg::CNT_W-1:0]   cnt_q;
	logic [mch_pkg::CNT_W-1:0]   cnt_d;
	logic [7:0]                  shift_q;
	logic                        mr_cap_q;
	logic                        mx_cap_q;
	logic                        mr_prev_q;
	logic                        mx_prev_q;
	logic                        dout_q;
	logic                        oe_b_q;
	logic                        core_rx_q;
	logic [mch_pkg::CTRL_W-1:0]  ctrl_q;
	logic [mch_pkg::STAT_W-1:0]  stat_q;
	logic [mch_pkg::STAT_W-1:0]  mask_q;
	logic [7:0]                  tx_byte_q;
	logic [7:0]                  rx_byte_q;
	logic                        tx_pend_q;
	logic                        rd_pend_q;
	logic                        rx_open_q;
	logic [31:0]                 prdata_q;
	mch_tx_state_t               tx_q;
	mch_tx_state_t               tx_d;
	mch_rx_state_t               rx_q;
	mch_rx_state_t               rx_d;

	mch_sync #(
		.W (mch_pkg::SYNC_W)
	) u_sync (
		.clk   (clk),
		.rst_b (rst_b),
		.pin   ({dcl, fsc, din}),
		.level (pins_s)
	);

	assign dcl_s = pins_s[2];
	assign fsc_s = pins_s[1];
	assign din_s = pins_s[0];

	////////////////////////////////////////////////////////////////////////////////
	// bit timing

	wire dcl_rise   = dcl_s & ~dcl_q;
	wire dcl_fall   = ~dcl_s & dcl_q;
	wire frame_tick = fsc_s & ~fsc_q;
	wire sub_sel    = ctrl_q[mch_pkg::CTL_SUBCH];

	assign cnt_d = frame_tick ? '0 :
		(dcl_rise && cnt_q != mch_pkg::LAST_BIT) ? cnt_q + 7'h01 : cnt_q;

	wire cap_mon = in_field(cnt_q, sub_sel, mch_pkg::MON_OFS, mch_pkg::MON_LEN);
	wire cap_mr  = in_field(cnt_q, sub_sel, mch_pkg::MR_OFS, 7'h01);
	wire cap_mx  = in_field(cnt_q, sub_sel, mch_pkg::MX_OFS, 7'h01);

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			dcl_q <= 1'b1;
			fsc_q <= 1'b1;
			cnt_q <= '0;
		end else begin
			dcl_q <= dcl_s;
			fsc_q <= fsc_s;
			cnt_q <= cnt_d;
		end
	end

	// inputs taken on the falling dcl edge, mid bit
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			shift_q  <= mch_pkg::BYTE_RST;
			mr_cap_q <= 1'b1;
			mx_cap_q <= 1'b1;
		end else if (dcl_fall) begin
			if (cap_mon) shift_q <= {shift_q[6:0], din_s};
			if (cap_mr) mr_cap_q <= din_s;
			if (cap_mx) mx_cap_q <= din_s;
		end
	end

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			mr_prev_q <= 1'b1;
			mx_prev_q <= 1'b1;
		end else if (frame_tick) begin
			mr_prev_q <= mr_cap_q;
			mx_prev_q <= mx_cap_q;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// transmitter

	wire tx_on  = ctrl_q[mch_pkg::CTL_TX_VALID];
	wire mr_now = mr_cap_q;
	wire mr_two = mr_cap_q & mr_prev_q;
	wire mr_ret = ~mr_cap_q & mr_prev_q;
	// valid is low only in TX_FIRST, TX_ACKED and TX_WAIT; idle high in the one-frame gap, in TX_CLOSE and in TX_IDLE
	wire tx_mx  = ~(tx_q == TX_FIRST || tx_q == TX_ACKED || tx_q == TX_WAIT);

	always_comb begin
		tx_d = tx_q;
		case (tx_q)
			TX_IDLE: begin
				if (tx_on) tx_d = TX_FIRST;
			end
			TX_FIRST: begin
				if (!tx_on) tx_d = TX_CLOSE;
				else if (!mr_now) tx_d = TX_ACKED;
			end
			TX_ACKED: begin
				if (!tx_on) tx_d = TX_CLOSE;
				else if (mr_two) tx_d = TX_CLOSE;
				else if (tx_pend_q) tx_d = TX_PULSE;
			end
			TX_PULSE: begin
				tx_d = tx_on ? TX_WAIT : TX_CLOSE;
			end
			TX_WAIT: begin
				if (!tx_on) tx_d = TX_CLOSE;
				else if (mr_two) tx_d = TX_CLOSE;
				else if (mr_ret) tx_d = TX_ACKED;
			end
			TX_CLOSE: begin
				// released only once the receiver lets go of the ack bit
				if (mr_now && !tx_on) tx_d = TX_IDLE;
			end
			default: tx_d = TX_IDLE;
		endcase
	end

	wire ev_acked = frame_tick && ((tx_q == TX_FIRST && tx_on && !mr_now) ||
		(tx_q == TX_WAIT && tx_on && !mr_two && mr_ret));
	wire ev_abort = frame_tick && tx_on && mr_two &&
		(tx_q == TX_ACKED || tx_q == TX_WAIT);
	wire tx_take  = frame_tick && tx_on &&
		(tx_q == TX_IDLE || (tx_q == TX_ACKED && !mr_two && tx_pend_q));

	////////////////////////////////////////////////////////////////////////////////
	// receiver

	wire rx_on    = ctrl_q[mch_pkg::CTL_RX_ACK];
	wire new_byte = frame_tick && !mx_cap_q && mx_prev_q;
	wire ev_end   = frame_tick && mx_cap_q && mx_prev_q && rx_open_q;
	wire rx_mr    = (rx_q == RX_OFF) || (rx_q == RX_PULSE);

	always_comb begin
		rx_d = rx_q;
		case (rx_q)
			RX_OFF: begin
				if (rx_on) rx_d = RX_ACK;
			end
			RX_ACK: begin
				if (!rx_on) rx_d = RX_OFF;
				else if (new_byte) rx_d = RX_HOLD;
			end
			RX_HOLD: begin
				// no timeout: held until software reads the byte
				if (!rx_on) rx_d = RX_OFF;
				else if (rd_pend_q) rx_d = RX_PULSE;
			end
			RX_PULSE: begin
				rx_d = rx_on ? RX_ACK : RX_OFF;
			end
			default: rx_d = RX_OFF;
		endcase
	end

	wire rd_clr = frame_tick && ((rx_q == RX_ACK && new_byte) || rx_q == RX_HOLD);

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			tx_q      <= TX_IDLE;
			rx_q      <= RX_OFF;
			rx_byte_q <= mch_pkg::BYTE_RST;
			rx_open_q <= 1'b0;
		end else begin
			if (frame_tick) tx_q <= tx_d;
			if (frame_tick) rx_q <= rx_d;
			if (new_byte) rx_byte_q <= shift_q;
			if (new_byte) rx_open_q <= 1'b1;
			else if (ev_end) rx_open_q <= 1'b0;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// serial output, changed on the rising dcl edge

	wire [2:0] bit_ix  = ~cnt_d[2:0];
	wire own_mon  = in_field(cnt_d, sub_sel, mch_pkg::MON_OFS, mch_pkg::MON_LEN);
	wire own_mr   = in_field(cnt_d, sub_sel, mch_pkg::MR_OFS, 7'h01);
	wire own_mx   = in_field(cnt_d, sub_sel, mch_pkg::MX_OFS, 7'h01);
	wire core_sl  = sub_sel && (in_field(cnt_d, 1'b0, mch_pkg::MON_OFS, mch_pkg::MON_LEN) ||
		in_field(cnt_d, 1'b0, mch_pkg::MR_OFS, 7'h02));
	wire out_bit  = own_mon ? tx_byte_q[bit_ix] :
		own_mr ? rx_mr : own_mx ? tx_mx : core_tx_bit;
	wire drive    = own_mon || own_mr || own_mx || core_sl;

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			dout_q    <= 1'b1;
			oe_b_q    <= 1'b1;
			core_rx_q <= 1'b1;
		end else begin
			if (frame_tick || dcl_rise) begin
				dout_q <= drive ? out_bit : 1'b1;
				oe_b_q <= ~drive;
			end
			core_rx_q <= din_s;
		end
	end

	assign dout_o      = dout_q;
	assign dout_oe_b   = oe_b_q;
	assign core_rx_bit = core_rx_q;

	////////////////////////////////////////////////////////////////////////////////
	// APB slave, zero wait states

	wire hit_ctrl = reg_hit(paddr, mch_pkg::CTRL_OFS);
	wire hit_stat = reg_hit(paddr, mch_pkg::STAT_OFS);
	wire hit_mask = reg_hit(paddr, mch_pkg::MASK_OFS);
	wire hit_act  = reg_hit(paddr, mch_pkg::ACT_OFS);
	wire hit_txb  = reg_hit(paddr, mch_pkg::TXB_OFS);
	wire hit_rxb  = reg_hit(paddr, mch_pkg::RXB_OFS);
	wire hit_any  = hit_ctrl | hit_stat | hit_mask | hit_act | hit_txb | hit_rxb;
	wire setup    = psel & ~penable;
	wire acc      = psel & penable;
	wire wr       = acc & pwrite & hit_any;
	wire rd_rxb   = acc & ~pwrite & hit_rxb;
	wire chan_act = (tx_q != TX_IDLE);

	wire [31:0] rd_mux =
		hit_ctrl ? {27'h0, ctrl_q} :
		hit_stat ? {28'h0000000, stat_q} :
		hit_mask ? {28'h0000000, mask_q} :
		hit_act  ? {31'h0, chan_act} :
		hit_txb  ? {24'h000000, tx_byte_q} :
		hit_rxb  ? {24'h000000, rx_byte_q} : 32'h00000000;

	wire [3:0] ev;
	assign ev[mch_pkg::ST_RECEIVED] = new_byte;
	assign ev[mch_pkg::ST_END_RX]   = ev_end;
	assign ev[mch_pkg::ST_ACKED]    = ev_acked;
	assign ev[mch_pkg::ST_ABORT]    = ev_abort;

	wire [3:0] w1c    = (wr && hit_stat) ? pwdata[3:0] : 4'h0;
	// set wins over a write-one-to-clear in the same cycle
	wire [3:0] stat_d = (stat_q & ~w1c) | ev;

	wire [3:0] irq_en;
	assign irq_en[mch_pkg::ST_RECEIVED] = 1'b1;
	assign irq_en[mch_pkg::ST_END_RX]   = ctrl_q[mch_pkg::CTL_RX_IRQEN];
	assign irq_en[mch_pkg::ST_ACKED]    = ctrl_q[mch_pkg::CTL_TX_IRQEN];
	assign irq_en[mch_pkg::ST_ABORT]    = ctrl_q[mch_pkg::CTL_TX_IRQEN];

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			ctrl_q    <= mch_pkg::CTRL_RST;
			stat_q    <= mch_pkg::STAT_RST;
			mask_q    <= mch_pkg::MASK_RST;
			tx_byte_q <= mch_pkg::BYTE_RST;
			prdata_q  <= 32'h00000000;
		end else begin
			stat_q <= stat_d;
			if (wr && hit_ctrl) ctrl_q <= pwdata[4:0];
			if (wr && hit_mask) mask_q <= pwdata[3:0];
			// a write mid-frame may split the byte on the wire; write after an acknowledge
			if (wr && hit_txb) tx_byte_q <= pwdata[7:0];
			if (setup) prdata_q <= rd_mux;
		end
	end

	// pending flags: a new request wins over the clear
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			tx_pend_q <= 1'b0;
			rd_pend_q <= 1'b0;
		end else begin
			tx_pend_q <= (wr && hit_txb) | (tx_pend_q & ~tx_take);
			rd_pend_q <= rd_rxb | (rd_pend_q & ~rd_clr);
		end
	end

	assign prdata  = prdata_q;
	assign pready  = 1'b1;
	assign pslverr = acc & ~hit_any;
	assign irq     = |(stat_q & mask_q & irq_en);

endmodule

/* File: sim/mch_top_props.sv */
// port assertions of the monitor channel handshake block
// assumes zero-wait APB; register shadows are rebuilt from bus writes
`timescale 1ns/1ps

module mch_top_props (
	input wire logic        clk,
	input wire logic        rst_b,
	input wire logic        psel,
	input wire logic        penable,
	input wire logic        pwrite,
	input wire logic [7:0]  paddr,
	input wire logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic        pready,
	input wire logic        pslverr,
	input wire logic        irq,
	input wire logic        dout_o,
	input wire logic        dout_oe_b
);
	logic [4:0] ctrl_q;
	logic [3:0] mask_q;
	logic [7:0] txb_q;
	wire        acc = psel && penable;
	wire        wr_acc = acc && pwrite;
	wire        rd_acc = acc && !pwrite;
	wire        mapped = paddr inside {8'h00, 8'h04, 8'h08, 8'h0C, 8'h10, 8'h14};
	// data received is the one status that no enable gates
	wire [3:0]  gate = mask_q & {ctrl_q[3], ctrl_q[3], ctrl_q[2], 1'b1};

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			ctrl_q <= mch_pkg::CTRL_RST;
			mask_q <= mch_pkg::MASK_RST;
			txb_q <= mch_pkg::BYTE_RST;
		end else if (wr_acc) begin
			if (paddr == mch_pkg::CTRL_OFS) ctrl_q <= pwdata[4:0];
			if (paddr == mch_pkg::MASK_OFS) mask_q <= pwdata[3:0];
			if (paddr == mch_pkg::TXB_OFS) txb_q <= pwdata[7:0];
		end
	end
	////////////////////////////////////////////////////////////////
	default clocking @(posedge clk); endclocking
	default disable iff (!rst_b);
	// one output change per link bit, and a bit lasts eight clocks
	sequence s_hold;
		$stable(dout_o)[*6];
	endsequence

	AST_PREADY: assert property (psel |-> pready) else $error("pready low");
	AST_ERR_UNMAPPED: assert property (acc && !mapped |-> pslverr) else $error("no pslverr");
	AST_OK_MAPPED: assert property (acc && mapped |-> !pslverr) else $error("bad pslverr");
	AST_ZERO_UNMAPPED: assert property (rd_acc && !mapped |-> prdata == 32'h0)
		else $error("unmapped read not zero");
	AST_CTRL_READ: assert property (rd_acc && paddr == 8'h00 |-> prdata == {27'h0, ctrl_q})
		else $error("control read wrong");
	AST_MASK_READ: assert property (rd_acc && paddr == 8'h08 |-> prdata == {28'h0, mask_q})
		else $error("mask read wrong");
	AST_TXB_READ: assert property (rd_acc && paddr == 8'h10 |-> prdata == {24'h0, txb_q})
		else $error("transmit byte read wrong");
	AST_ACT_READ: assert property (rd_acc && paddr == 8'h0C |-> prdata[31:1] == 31'h0)
		else $error("active read wrong");
	AST_IRQ_GATE: assert property (gate == 4'h0 |-> !irq) else $error("irq not gated");
	AST_DOUT_HOLD: assert property ($changed(dout_o) |=> s_hold) else $error("dout glitch");
	// a released line must idle high so the pull-up level is never fought
	AST_OE_RELEASE: assert property (dout_oe_b |-> dout_o) else $error("released line not high");
endmodule

bind mch_top mch_top_props mch_top_props_i (.clk(clk), .rst_b(rst_b), .psel(psel),
	.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
	.pready(pready), .pslverr(pslverr), .irq(irq), .dout_o(dout_o), .dout_oe_b(dout_oe_b));

/* File: sim/mch_partner.sv */
// far device on the terminal bus: makes dcl, fsc and din, captures dout
// assumes pull-ups on both serial lines; bits it does not own read one
`timescale 1ns/1ps

module mch_partner (
	output logic             dcl,
	output logic             fsc,
	output logic             din,
	input  wire logic        dout_o,
	input  wire logic        dout_oe_b,
	input  wire logic [95:0] tx_frame,
	output logic      [95:0] rx_frame,
	output int               fcnt
);
	logic [95:0] cap;
	wire         dout_w = dout_oe_b ? 1'b1 : dout_o;

	// the bus clock runs free; tx_frame is read live, msb first
	initial begin
		dcl = 1'b0;
		fsc = 1'b0;
		din = 1'b1;
		cap = '1;
		rx_frame = '1;
		fcnt = 0;
		#1010;
		forever begin
			for (int b = 0; b < 96; b++) begin
				dcl = 1'b1;
				fsc = (b == 0);
				din = tx_frame[95-b];
				#200 dcl = 1'b0;
				#190 cap[95-b] = dout_w;
				#10;
			end
			rx_frame = cap;
			fcnt++;
		end
	end
endmodule

/* File: sim/mch_top_tb_top.sv */
// self-checking bench of the monitor channel handshake block
// assumes the partner model owns the serial bus; remote sits on sub-channel 0
`timescale 1ns/1ps

module mch_top_tb_top;
	typedef struct packed {
		logic        w;
		logic [7:0]  a;
		logic [31:0] d;
		logic [31:0] q;
		logic        e;
	} mch_row_t;
	logic        clk, rst_b, psel, penable, pwrite, pready, pslverr, irq, e;
	logic [7:0]  paddr;
	logic [31:0] pwdata, prdata, q;
	logic        dcl, fsc, din, dout_o, dout_oe_b, core_tx_bit, core_rx_bit;
	logic [95:0] tx_frame, rx_frame;
	int          fcnt, err_count, cmp_count, cyc, n;
	mch_row_t    rows [15] = '{
		'{1'b0, 8'h00, 32'h0, 32'h0, 1'b0}, '{1'b0, 8'h04, 32'h0, 32'h0, 1'b0},
		'{1'b0, 8'h08, 32'h0, 32'h0, 1'b0}, '{1'b0, 8'h0C, 32'h0, 32'h0, 1'b0},
		'{1'b0, 8'h10, 32'h0, 32'hFF, 1'b0}, '{1'b0, 8'h14, 32'h0, 32'hFF, 1'b0},
		'{1'b1, 8'h08, 32'hF, 32'h0, 1'b0}, '{1'b0, 8'h08, 32'h0, 32'hF, 1'b0},
		'{1'b1, 8'h14, 32'h0, 32'h0, 1'b0}, '{1'b0, 8'h14, 32'h0, 32'hFF, 1'b0},
		'{1'b1, 8'h00, 32'h10, 32'h0, 1'b0}, '{1'b0, 8'h00, 32'h0, 32'h10, 1'b0},
		'{1'b1, 8'h00, 32'h0, 32'h0, 1'b0}, '{1'b0, 8'h18, 32'h0, 32'h0, 1'b1},
		'{1'b1, 8'h1C, 32'h5, 32'h0, 1'b1}};

	mch_top mch_top_i (.clk(clk), .rst_b(rst_b), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .irq(irq), .dcl(dcl), .fsc(fsc), .din(din), .dout_o(dout_o),
		.dout_oe_b(dout_oe_b), .core_tx_bit(core_tx_bit), .core_rx_bit(core_rx_bit));
	mch_partner mch_partner_i (.dcl(dcl), .fsc(fsc), .din(din), .dout_o(dout_o),
		.dout_oe_b(dout_oe_b), .tx_frame(tx_frame), .rx_frame(rx_frame), .fcnt(fcnt));
	////////////////////////////////////////////////////////////////
	initial clk = 1'b0;
	always #25 clk = ~clk;
	always @(posedge clk) begin
		cyc++;
		if (cyc == 90000) begin
			err_count++;
			results();
		end
	end
	task automatic results();
		if (err_count == 0 && cmp_count > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask
	task automatic chk(input logic [31:0] s, input logic [31:0] x);
		cmp_count++;
		if (s !== x) begin
			err_count++;
			$display("[FAIL] %0t saw %h expected %h", $time, s, x);
		end
	endtask
	// entered and left just after a rising edge
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		do @(posedge clk); while (pready !== 1'b1);
		q = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge clk);
	endtask
	// no timeout of its own: waits k frames of the free-running partner
	task automatic fr(input int k);
		repeat (k) @(fcnt);
		@(posedge clk);
	endtask
	task automatic far(input logic [7:0] b, input logic mr, input logic mx);
		tx_frame <= {16'hFFFF, b, 6'h3F, mr, mx, 64'hFFFFFFFFFFFFFFFF};
	endtask
	function automatic logic [31:0] byt(input int c);
		return {24'h0, rx_frame[79-c*32 -: 8]};
	endfunction
	function automatic logic [31:0] mrb(input int c);
		return {31'h0, rx_frame[65-c*32]};
	endfunction
	function automatic logic [31:0] mxb(input int c);
		return {31'h0, rx_frame[64-c*32]};
	endfunction
	////////////////////////////////////////////////////////////////
	initial begin
		rst_b = 1'b0;
		{psel, penable, pwrite, paddr, pwdata, core_tx_bit} = 44'h0;
		tx_frame = '1;
		repeat (10) @(posedge clk);
		chk({30'h0, dout_oe_b, irq}, 32'h2);
		rst_b <= 1'b1;
		@(posedge clk);
		foreach (rows[i]) begin
			apb(rows[i].w, rows[i].a, rows[i].d);
			if (!rows[i].w) chk(q, rows[i].q);
			chk({31'h0, e}, {31'h0, rows[i].e});
		end
		// transmitter, the partner receives
		apb(1'b1, 8'h10, 32'hA5);
		apb(1'b1, 8'h00, 32'h0A);
		fr(2);
		chk({23'h0, rx_frame[79:72], rx_frame[64]}, 32'h14A);
		fr(1);
		chk(byt(0), 32'hA5);
		apb(1'b0, 8'h04, 32'h0);
		chk(q, 32'h0);
		far(8'hFF, 1'b0, 1'b1);
		fr(2);
		apb(1'b0, 8'h04, 32'h0);
		chk({q[30:0], irq}, 32'h9);
		apb(1'b1, 8'h04, 32'h4);
		chk({31'h0, irq}, 32'h0);
		apb(1'b1, 8'h10, 32'h3C);
		n = 0;
		repeat (4) begin
			fr(1);
			n += mxb(0);
		end
		chk(n, 32'h1);
		chk(byt(0), 32'h3C);
		far(8'hFF, 1'b1, 1'b1);
		fr(1);
		far(8'hFF, 1'b0, 1'b1);
		fr(2);
		apb(1'b0, 8'h04, 32'h0);
		chk(q, 32'h4);
		apb(1'b1, 8'h04, 32'hF);
		apb(1'b1, 8'h00, 32'h08);
		fr(2);
		apb(1'b0, 8'h0C, 32'h0);
		chk({q[30:0], rx_frame[64]}, 32'h3);
		far(8'hFF, 1'b1, 1'b1);
		fr(2);
		apb(1'b0, 8'h0C, 32'h0);
		chk(q, 32'h0);
		// receiver asks for an abort in mid-message
		apb(1'b1, 8'h10, 32'h5A);
		apb(1'b1, 8'h00, 32'h0A);
		fr(2);
		far(8'hFF, 1'b0, 1'b1);
		fr(2);
		apb(1'b1, 8'h04, 32'hF);
		far(8'hFF, 1'b1, 1'b1);
		fr(3);
		apb(1'b0, 8'h04, 32'h0);
		chk({q[30:0], rx_frame[64]}, 32'h11);
		apb(1'b1, 8'h00, 32'h0);
		fr(2);
		apb(1'b0, 8'h0C, 32'h0);
		chk(q, 32'h0);
		// receiver, the partner transmits
		apb(1'b1, 8'h04, 32'hF);
		far(8'h96, 1'b1, 1'b0);
		fr(2);
		apb(1'b0, 8'h04, 32'h0);
		chk(q, 32'h1);
		apb(1'b0, 8'h14, 32'h0);
		chk({q[30:0], rx_frame[65]}, 32'h12D);
		apb(1'b1, 8'h00, 32'h05);
		fr(2);
		chk(mrb(0), 32'h0);
		apb(1'b1, 8'h04, 32'hF);
		far(8'h96, 1'b1, 1'b1);
		fr(1);
		far(8'h69, 1'b1, 1'b0);
		fr(2);
		apb(1'b0, 8'h04, 32'h0);
		chk(q, 32'h1);
		apb(1'b0, 8'h14, 32'h0);
		chk(q, 32'h69);
		n = 0;
		repeat (4) begin
			fr(1);
			n += mrb(0);
		end
		chk(n, 32'h1);
		far(8'hFF, 1'b1, 1'b1);
		fr(3);
		apb(1'b0, 8'h04, 32'h0);
		chk(q, 32'h3);
		apb(1'b1, 8'h08, 32'h2);
		chk({31'h0, irq}, 32'h1);
		apb(1'b1, 8'h00, 32'h01);
		chk({31'h0, irq}, 32'h0);
		apb(1'b1, 8'h00, 32'h0);
		fr(2);
		chk(mrb(0), 32'h1);
		// sub-channel 1 for the processor, sub-channel 0 from the core
		apb(1'b1, 8'h10, 32'hC3);
		apb(1'b1, 8'h00, 32'h12);
		fr(2);
		chk({23'h0, rx_frame[47:40], rx_frame[32]}, 32'h186);
		chk(byt(0) | mxb(0), 32'h0);
		core_tx_bit <= 1'b1;
		fr(2);
		chk(byt(0), 32'hFF);
		tx_frame <= '0;
		fr(1);
		chk({31'h0, core_rx_bit}, 32'h0);
		// reset in mid-run: outputs idle, control back to its defaults
		rst_b <= 1'b0;
		repeat (2) @(posedge clk);
		chk({29'h0, dout_o, dout_oe_b, irq}, 32'h6);
		rst_b <= 1'b1;
		@(posedge clk);
		apb(1'b0, 8'h00, 32'h0);
		chk(q, 32'h0);
		results();
	end
endmodule
